/* sfws_host_model.sv */
// Serial host model: clocks words through the block
`default_nettype none
module sfws_host_model (
  input  wire logic        i_go,
  input  wire logic [5:0]  i_len,
  input  wire logic [31:0] i_word,
  input  wire logic        i_sdo,
  output var  logic        o_sck,
  output var  logic        o_sdi,
  output var  logic [31:0] o_rx,
  output var  logic        o_done
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {o_sck, o_sdi, o_rx, o_done} = {1'b1, 1'b0, 32'h0, 1'b0};
    forever
    begin
      @(posedge i_go);
      o_done = 1'b0;
      o_rx = '0;
      #7;
      for (int i = 1; i <= i_len; i++)
      begin
        o_sck = 1'b0;
        o_sdi = i_word[i_len - i];
        #160 o_sck = 1'b1;
        // Late capture: output moves only after the falling edge
        #160 o_rx = {o_rx[30:0], i_sdo};
      end
      o_sdi = !o_sdi;  // Released line shows no stale bit
      o_done = 1'b1;
    end
  end
endmodule : sfws_host_model
`default_nettype wire

/* sfws_mem.sv */
// Word memory with registered read data, used for the transmit and receive queues
`default_nettype none
module sfws_mem (
  input  wire logic                       i_clk,
  input  wire logic                       i_wr_en,
  input  wire logic [sfws_pkg::AW-1:0]    i_wr_addr,
  input  wire logic [sfws_pkg::DW-1:0]    i_wr_data,
  input  wire logic [sfws_pkg::AW-1:0]    i_rd_addr,
  output var  logic [sfws_pkg::DW-1:0]    o_rd_data
);
  logic [sfws_pkg::DW-1:0] mem [0:(1<<sfws_pkg::AW)-1];

  always_ff @(posedge i_clk)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end
endmodule : sfws_mem
`default_nettype wire

/* sfws_pkg.sv */
// Package with register map, field positions and types of the framing and status block
`default_nettype none
package sfws_pkg;
  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_FRAME = 8'h04;
  localparam logic [7:0] ADDR_WLEN  = 8'h08;
  localparam logic [7:0] ADDR_STAT  = 8'h0c;
  localparam logic [7:0] ADDR_FILL  = 8'h10;
  localparam logic [7:0] ADDR_DATA  = 8'h14;
  localparam logic [7:0] ADDR_URDT  = 8'h18;
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTRL_EN    = 15;
  localparam int CTRL_WIDE  = 11;
  localparam int CTRL_MID   = 10;
  localparam int CTRL_HOST  = 5;
  localparam int CTRL_ENH   = 0;
  localparam int FR_AUD_EN  = 15;
  localparam int FR_IGN_TUR = 12;
  localparam int FR_URDT    = 10;
  localparam int FR_FMT     = 8;
  localparam int FR_FRAMED_MODE_ENABLE   = 7;
  localparam int FR_DIR     = 6;
  localparam int FR_POL     = 5;
  localparam int FR_SSA     = 4;
  localparam int FR_PW      = 3;
  localparam int FR_CNT     = 0;
  localparam int ST_FRAME_ERROR_FLAG  = 12;
  localparam int ST_BUSY    = 11;
  localparam int ST_TUR     = 8;
  localparam int ST_SHIFTER_EMPTY_FLAG    = 7;
  localparam int ST_ROV     = 6;
  localparam int ST_RBE     = 5;
  localparam int ST_TBE     = 3;
  localparam int ST_TBF     = 1;
  localparam int ST_RBF     = 0;
  localparam int FILL_RX    = 8;
  // ------------------------------------------------------------------
  // Masks, reset values, codes and sizes
  // ------------------------------------------------------------------
  localparam logic [31:0] CTRL_WMASK   = 32'h0000_8c21;
  localparam logic [31:0] FRAME_WMASK  = 32'h0000_ffff;
  localparam logic [31:0] AUDIO_LOCKED = 32'h0000_8b00;
  localparam logic [31:0] WLEN_WMASK   = 32'h0000_001f;
  localparam logic [31:0] FLAG_W1C     = 32'h0000_1040;
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  localparam logic [15:0] FRAME_RST    = 16'h0000;
  localparam logic [4:0]  WLEN_RST     = 5'h00;
  localparam logic [31:0] URDT_RST     = 32'h0000_0000;
  localparam logic [1:0]  FMT_PCM      = 2'h3;
  localparam logic [2:0]  CNT_AUDIO    = 3'h1;
  localparam int          DW           = 32;
  localparam int          AW           = 6;
  localparam logic [5:0]  FILL_FULL    = 6'h3f;
  localparam logic [5:0]  FILL_STD     = 6'h01;

  typedef struct packed {
    logic       en;
    logic       host;
    logic       enh;
    logic       framed;
    logic       dir_in;
    logic       pol;
    logic       ssa;
    logic       wide_fs;
    logic [2:0] cnt;
    logic [5:0] len;
    logic       ign_tur;
    logic       urdt;
  } sfws_cfg_t;
endpackage : sfws_pkg
`default_nettype wire

/* sfws_sva.sv */
// Checker of bus answers and select pin levels
`default_nettype none
module sfws_sva (
  input wire logic        I_CLOCK,
  input wire logic        I_ARST_N,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic [7:0]  I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [31:0] O_WB_DAT,
  input wire logic        O_WB_ACK,
  input wire logic        O_SDO,
  input wire logic        O_SEL,
  input wire logic        O_SEL_OE
);
  logic en, aud, frm, dir, pol, ssa;
  wire logic wr = I_WB_CYC & I_WB_STB & I_WB_WE & !O_WB_ACK;
  wire logic [5:0] cfg = {en, aud, frm, dir, pol, ssa};
  // Shadow config; audio bit frozen while enabled
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    if (!I_ARST_N)
      {en, aud, frm, dir, pol, ssa} <= '0;
    else if (wr && I_WB_ADR == sfws_pkg::ADDR_CTRL)
      en <= I_WB_DAT[sfws_pkg::CTRL_EN];
    else if (wr && I_WB_ADR == sfws_pkg::ADDR_FRAME)
      {aud, frm, dir, pol, ssa} <= {en ? aud : I_WB_DAT[sfws_pkg::FR_AUD_EN], I_WB_DAT[7:4]};
  // Stable shadow only: the pins are registered one cycle behind
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);
  sequence s_req; I_WB_CYC && I_WB_STB && !O_WB_ACK; endsequence
  sequence s_pulse; O_WB_ACK ##1 !O_WB_ACK; endsequence
  AST_ACK_ANSWER: assert property (s_req |=> s_pulse) else $error("ack missing");
  AST_ACK_CAUSE: assert property ($rose(O_WB_ACK) |-> $past(I_WB_CYC && I_WB_STB)) else $error("stray ack");
  AST_ACK_SINGLE: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("long ack");
  AST_DAT_HOLD: assert property (!O_WB_ACK |-> $stable(O_WB_DAT)) else $error("read data moved");
  AST_SDO_OFF: assert property (!en && $stable(cfg) |-> !O_SDO)
    else $error("data out while off");
  AST_SEL_IDLE: assert property (!en && $stable(cfg) |-> O_SEL == !pol)
    else $error("select not idle");
  AST_OE_CLIENT: assert property (frm && dir && !aud && $stable(cfg) |-> !O_SEL_OE)
    else $error("sync driven");
  AST_OE_PORT: assert property (!frm && !ssa && !aud && $stable(cfg) |-> !O_SEL_OE)
    else $error("select driven");
endmodule : sfws_sva
bind sfws_top sfws_sva i_sva (.*);
`default_nettype wire

/* sfws_top.sv */
// Serial framing, word length and transfer status block with a Wishbone register slave
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`default_nettype none
module sfws_top (
  input  wire logic        I_CLOCK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output var  logic [31:0] O_WB_DAT,
  output var  logic        O_WB_ACK,
  input  wire logic        I_SCK,
  input  wire logic        I_SDI,
  input  wire logic        I_SEL,
  output var  logic        O_SDO,
  output var  logic        O_SEL,
  output var  logic        O_SEL_OE
);
  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] sel, input logic [31:0] wmask);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        m[8*b +: 8] = d[8*b +: 8];
      end
    end
    return (m & wmask) | (old & ~wmask);
  endfunction : wb_merge

  function automatic logic [31:0] len_mask(input logic [5:0] len);
    return ~(32'hffff_ffff << len);
  endfunction : len_mask

  function automatic logic [5:0] word_len(input logic aud, input logic [4:0] vwl,
                                          input logic wide, input logic mid);
    if (!aud && (vwl != 5'h00))
    begin
      return {1'b0, vwl} + 6'h01;
    end
    else if (wide)
    begin
      return 6'h20;
    end
    else if (mid)
    begin
      return 6'h10;
    end
    return 6'h08;
  endfunction : word_len

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [15:0] ctrl_reg;
  logic [15:0] frame_reg;
  logic [4:0]  wlen_reg;
  logic [31:0] urdt_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic        frame_error_flag_reg;
  logic        rov_reg;
  logic        tur_reg;
  logic        halted_reg;
  logic [5:0]  tx_cnt_reg;
  logic [5:0]  tx_wp_reg;
  logic [5:0]  tx_rp_reg;
  logic [5:0]  rx_cnt_reg;
  logic [5:0]  rx_wp_reg;
  logic [5:0]  rx_rp_reg;
  logic [2:0]  sck_sync_reg;
  logic [1:0]  sdi_sync_reg;
  logic [1:0]  sel_sync_reg;
  logic [4:0]  bit_cnt_reg;
  logic [4:0]  word_idx_reg;
  logic [31:0] tx_sh_reg;
  logic [31:0] rx_sh_reg;
  logic [31:0] last_rx_reg;
  logic        loaded_reg;
  logic        frame_go_reg;
  logic        fs_act_reg;
  logic        fs_prev_reg;
  logic        sdo_reg;
  logic        sel_out_reg;
  logic        sel_oe_reg;
  logic [31:0] tx_q;
  logic [31:0] rx_q;

  // ------------------------------------------------------------------
  // Effective configuration
  // ------------------------------------------------------------------
  sfws_pkg::sfws_cfg_t cfg;
  wire         aud = frame_reg[sfws_pkg::FR_AUD_EN];
  wire   [1:0] fmt = frame_reg[sfws_pkg::FR_FMT +: 2];
  assign cfg.en      = ctrl_reg[sfws_pkg::CTRL_EN];
  assign cfg.host    = ctrl_reg[sfws_pkg::CTRL_HOST];
  assign cfg.enh     = ctrl_reg[sfws_pkg::CTRL_ENH];
  assign cfg.framed  = frame_reg[sfws_pkg::FR_FRAMED_MODE_ENABLE] | aud;
  assign cfg.dir_in  = aud ? ~cfg.host : frame_reg[sfws_pkg::FR_DIR];
  assign cfg.pol     = frame_reg[sfws_pkg::FR_POL];
  assign cfg.ssa     = frame_reg[sfws_pkg::FR_SSA];
  assign cfg.wide_fs = frame_reg[sfws_pkg::FR_PW] | (aud & (fmt != sfws_pkg::FMT_PCM));
  assign cfg.cnt     = aud ? sfws_pkg::CNT_AUDIO : frame_reg[sfws_pkg::FR_CNT +: 3];
  assign cfg.len     = word_len(aud, wlen_reg, ctrl_reg[sfws_pkg::CTRL_WIDE], ctrl_reg[sfws_pkg::CTRL_MID]);
  assign cfg.ign_tur = frame_reg[sfws_pkg::FR_IGN_TUR];
  assign cfg.urdt    = frame_reg[sfws_pkg::FR_URDT];

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  wire        wb_acc   = I_WB_CYC & I_WB_STB & ~ack_reg;
  wire        wb_wr    = wb_acc & I_WB_WE;
  wire        wb_rd    = wb_acc & ~I_WB_WE;
  wire        wr_ctrl  = wb_wr & (I_WB_ADR == sfws_pkg::ADDR_CTRL);
  wire        wr_frame = wb_wr & (I_WB_ADR == sfws_pkg::ADDR_FRAME);
  wire        wr_wlen  = wb_wr & (I_WB_ADR == sfws_pkg::ADDR_WLEN);
  wire        wr_stat  = wb_wr & (I_WB_ADR == sfws_pkg::ADDR_STAT);
  wire        wr_data  = wb_wr & (I_WB_ADR == sfws_pkg::ADDR_DATA);
  wire        wr_urdt  = wb_wr & (I_WB_ADR == sfws_pkg::ADDR_URDT);
  wire        rd_data  = wb_rd & (I_WB_ADR == sfws_pkg::ADDR_DATA);
  wire [31:0] frame_wm = cfg.en ? (sfws_pkg::FRAME_WMASK & ~sfws_pkg::AUDIO_LOCKED)
                                : sfws_pkg::FRAME_WMASK;
  wire [31:0] ctrl_new  = wb_merge({16'h0000, ctrl_reg}, I_WB_DAT, I_WB_SEL, sfws_pkg::CTRL_WMASK);
  wire [31:0] frame_new = wb_merge({16'h0000, frame_reg}, I_WB_DAT, I_WB_SEL, frame_wm);
  wire [31:0] wlen_new  = wb_merge({27'h0, wlen_reg}, I_WB_DAT, I_WB_SEL, sfws_pkg::WLEN_WMASK);
  wire [31:0] clr_bits  = wr_stat ? wb_merge(32'h0, I_WB_DAT, I_WB_SEL, sfws_pkg::FLAG_W1C) : 32'h0;

  // ------------------------------------------------------------------
  // Queue flags
  // ------------------------------------------------------------------
  wire tx_empty = (tx_cnt_reg == 6'h00);
  wire rx_empty = (rx_cnt_reg == 6'h00);
  wire tx_full  = cfg.enh ? (tx_cnt_reg == sfws_pkg::FILL_FULL) : (tx_cnt_reg == sfws_pkg::FILL_STD);
  wire rx_full  = cfg.enh ? (rx_cnt_reg == sfws_pkg::FILL_FULL) : (rx_cnt_reg == sfws_pkg::FILL_STD);
  wire busy     = loaded_reg | (bit_cnt_reg != 5'h00);
  wire shifter_empty_flag     = tx_empty & ~loaded_reg;

  // ------------------------------------------------------------------
  // Serial engine decode
  // ------------------------------------------------------------------
  wire        sck_rise   = sck_sync_reg[1] & ~sck_sync_reg[2];
  wire        sck_fall   = ~sck_sync_reg[1] & sck_sync_reg[2];
  wire        run        = cfg.en & ~halted_reg;
  wire        fs_in_act  = ~(sel_sync_reg[1] ^ cfg.pol);
  wire        client_fr  = cfg.framed & cfg.dir_in;
  wire        host_fr    = cfg.framed & ~cfg.dir_in;
  wire        start_now  = client_fr & fs_in_act & (bit_cnt_reg == 5'h00) & ~frame_go_reg;
  wire        bits_ok    = loaded_reg & (~client_fr | frame_go_reg | start_now);
  wire [4:0]  len_m1     = cfg.len[4:0] - 5'h01;
  wire [4:0]  grp_m1     = (cfg.cnt > 3'h5) ? 5'h00 : 5'((6'h01 << cfg.cnt) - 6'h01);
  wire        do_load    = run & sck_fall & (bit_cnt_reg == 5'h00) & ~loaded_reg;
  wire        underrun   = do_load & tx_empty;
  wire        halt_ev    = underrun & ~cfg.ign_tur;
  wire        load_ok    = do_load & ~halt_ev;
  wire        tx_pop     = load_ok & ~tx_empty;
  wire        tx_push    = wr_data & ~tx_full;
  wire        do_bit     = run & sck_rise & bits_ok;
  wire        complete   = do_bit & (bit_cnt_reg == len_m1);
  wire        grp_end    = (word_idx_reg == grp_m1);
  wire [31:0] rx_word    = {rx_sh_reg[30:0], sdi_sync_reg[1]} & len_mask(cfg.len);
  wire        rx_push    = complete & ~rx_full;
  wire        rx_pop     = rd_data & ~rx_empty;
  wire        frm_err_ev = run & sck_rise & client_fr & fs_in_act & ~fs_prev_reg
                           & (bit_cnt_reg != 5'h00);
  wire [31:0] fill_word  = cfg.urdt ? urdt_reg : last_rx_reg;
  wire [31:0] tx_src     = tx_empty ? (cfg.ign_tur ? fill_word : 32'h0) : tx_q;
  wire [5:0]  sh_amt     = 6'h20 - cfg.len;
  wire [31:0] tx_aligned = (tx_src & len_mask(cfg.len)) << sh_amt;
  wire        sel_act    = host_fr ? fs_act_reg : busy;
  wire        sel_oe_nx  = cfg.en & (host_fr | (~cfg.framed & cfg.ssa & cfg.host));
  wire        sel_out_nx = sel_act ^ ~cfg.pol;

  // ------------------------------------------------------------------
  // Status and read mux
  // ------------------------------------------------------------------
  logic [31:0] stat_word;
  always_comb
  begin
    stat_word                       = 32'h0;
    stat_word[sfws_pkg::ST_FRAME_ERROR_FLAG]  = frame_error_flag_reg;
    stat_word[sfws_pkg::ST_BUSY]    = busy;
    stat_word[sfws_pkg::ST_TUR]     = tur_reg;
    stat_word[sfws_pkg::ST_SHIFTER_EMPTY_FLAG]    = shifter_empty_flag;
    stat_word[sfws_pkg::ST_ROV]     = rov_reg;
    stat_word[sfws_pkg::ST_RBE]     = rx_empty;
    stat_word[sfws_pkg::ST_TBE]     = tx_empty;
    stat_word[sfws_pkg::ST_TBF]     = tx_full;
    stat_word[sfws_pkg::ST_RBF]     = rx_full;
  end

  logic [31:0] rd_mux;
  always_comb
  begin
    case (I_WB_ADR)
      sfws_pkg::ADDR_CTRL:  rd_mux = {16'h0000, ctrl_reg};
      sfws_pkg::ADDR_FRAME: rd_mux = {16'h0000, frame_reg};
      sfws_pkg::ADDR_WLEN:  rd_mux = {27'h0, wlen_reg};
      sfws_pkg::ADDR_STAT:  rd_mux = stat_word;
      sfws_pkg::ADDR_FILL:  rd_mux = {18'h0, rx_cnt_reg, 2'h0, tx_cnt_reg};
      sfws_pkg::ADDR_DATA:  rd_mux = rx_q;
      sfws_pkg::ADDR_URDT:  rd_mux = urdt_reg;
      default:              rd_mux = 32'h0;
    endcase
  end

  // ------------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0;
      ctrl_reg  <= sfws_pkg::CTRL_RST;
      frame_reg <= sfws_pkg::FRAME_RST;
      wlen_reg  <= sfws_pkg::WLEN_RST;
      urdt_reg  <= sfws_pkg::URDT_RST;
    end
    else
    begin
      ack_reg <= wb_acc;
      if (wb_rd)
      begin
        dat_reg <= rd_mux;
      end
      if (wr_ctrl)
      begin
        ctrl_reg <= ctrl_new[15:0];
      end
      if (wr_frame)
      begin
        frame_reg <= frame_new[15:0];
      end
      if (wr_wlen)
      begin
        wlen_reg <= wlen_new[4:0];
      end
      if (wr_urdt)
      begin
        urdt_reg <= wb_merge(urdt_reg, I_WB_DAT, I_WB_SEL, 32'hffff_ffff);
      end
    end
  end

  // ------------------------------------------------------------------
  // Flags and queue counters
  // ------------------------------------------------------------------
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      frame_error_flag_reg <= 1'b0;
      rov_reg    <= 1'b0;
      tur_reg    <= 1'b0;
      halted_reg <= 1'b0;
      tx_cnt_reg <= 6'h00;
      tx_wp_reg  <= 6'h00;
      tx_rp_reg  <= 6'h00;
      rx_cnt_reg <= 6'h00;
      rx_wp_reg  <= 6'h00;
      rx_rp_reg  <= 6'h00;
    end
    else
    begin
      frame_error_flag_reg <= frm_err_ev | (frame_error_flag_reg & ~clr_bits[sfws_pkg::ST_FRAME_ERROR_FLAG]);
      rov_reg    <= (complete & rx_full) | (rov_reg & ~clr_bits[sfws_pkg::ST_ROV]);
      if (!cfg.en)
      begin
        tur_reg    <= 1'b0;
        halted_reg <= 1'b0;
        tx_cnt_reg <= 6'h00;
        tx_wp_reg  <= 6'h00;
        tx_rp_reg  <= 6'h00;
        rx_cnt_reg <= 6'h00;
        rx_wp_reg  <= 6'h00;
        rx_rp_reg  <= 6'h00;
      end
      else
      begin
        if (do_load)
        begin
          tur_reg <= cfg.ign_tur ? tx_empty : (tur_reg | tx_empty);
        end
        halted_reg <= halted_reg | halt_ev;
        tx_wp_reg  <= tx_push ? tx_wp_reg + 6'h01 : tx_wp_reg;
        tx_rp_reg  <= tx_pop ? tx_rp_reg + 6'h01 : tx_rp_reg;
        tx_cnt_reg <= tx_cnt_reg + {5'h00, tx_push} - {5'h00, tx_pop};
        rx_wp_reg  <= rx_push ? rx_wp_reg + 6'h01 : rx_wp_reg;
        rx_rp_reg  <= rx_pop ? rx_rp_reg + 6'h01 : rx_rp_reg;
        rx_cnt_reg <= rx_cnt_reg + {5'h00, rx_push} - {5'h00, rx_pop};
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      sck_sync_reg <= 3'h0;
      sdi_sync_reg <= 2'h0;
      sel_sync_reg <= 2'h0;
    end
    else
    begin
      sck_sync_reg <= {sck_sync_reg[1:0], I_SCK};
      sdi_sync_reg <= {sdi_sync_reg[0], I_SDI};
      sel_sync_reg <= {sel_sync_reg[0], I_SEL};
    end
  end

  // ------------------------------------------------------------------
  // Serial engine
  // ------------------------------------------------------------------
  // Data leaves on falling edges and is sampled on rising edges
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      bit_cnt_reg  <= 5'h00;
      word_idx_reg <= 5'h00;
      tx_sh_reg    <= 32'h0;
      rx_sh_reg    <= 32'h0;
      last_rx_reg  <= 32'h0;
      loaded_reg   <= 1'b0;
      frame_go_reg <= 1'b0;
      fs_act_reg   <= 1'b0;
      fs_prev_reg  <= 1'b0;
      sdo_reg      <= 1'b0;
    end
    else if (!cfg.en)
    begin
      bit_cnt_reg  <= 5'h00;
      word_idx_reg <= 5'h00;
      rx_sh_reg    <= 32'h0;
      loaded_reg   <= 1'b0;
      frame_go_reg <= 1'b0;
      fs_act_reg   <= 1'b0;
      sdo_reg      <= 1'b0;
    end
    else
    begin
      if (load_ok)
      begin
        loaded_reg <= 1'b1;
        sdo_reg    <= tx_aligned[31];
        tx_sh_reg  <= tx_aligned << 1;
        fs_act_reg <= host_fr & (word_idx_reg == 5'h00);
      end
      else if (run & sck_fall & loaded_reg)
      begin
        sdo_reg   <= tx_sh_reg[31];
        tx_sh_reg <= tx_sh_reg << 1;
        if (!cfg.wide_fs)
        begin
          fs_act_reg <= 1'b0;
        end
      end
      else if (run & sck_fall & ~loaded_reg & ~cfg.wide_fs)
      begin
        fs_act_reg <= 1'b0;
      end
      if (run & sck_rise)
      begin
        fs_prev_reg <= fs_in_act;
      end
      if (start_now & sck_rise & run)
      begin
        frame_go_reg <= 1'b1;
      end
      if (do_bit)
      begin
        rx_sh_reg   <= {rx_sh_reg[30:0], sdi_sync_reg[1]};
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
      if (complete)
      begin
        bit_cnt_reg  <= 5'h00;
        rx_sh_reg    <= 32'h0;
        last_rx_reg  <= rx_word;
        loaded_reg   <= 1'b0;
        word_idx_reg <= grp_end ? 5'h00 : word_idx_reg + 5'h01;
        if (grp_end)
        begin
          frame_go_reg <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      sel_out_reg <= 1'b1;
      sel_oe_reg  <= 1'b0;
    end
    else
    begin
      sel_out_reg <= sel_out_nx;
      sel_oe_reg  <= sel_oe_nx;
    end
  end

  assign O_WB_ACK = ack_reg;
  assign O_WB_DAT = dat_reg;
  assign O_SDO    = sdo_reg;
  assign O_SEL    = sel_out_reg;
  assign O_SEL_OE = sel_oe_reg;

  // ------------------------------------------------------------------
  // Queue memories, depth independent of word length
  // ------------------------------------------------------------------
  sfws_mem u_tx_mem (
    .i_clk     (I_CLOCK),
    .i_wr_en   (tx_push),
    .i_wr_addr (tx_wp_reg),
    .i_wr_data (I_WB_DAT),
    .i_rd_addr (tx_rp_reg),
    .o_rd_data (tx_q)
  );

  sfws_mem u_rx_mem (
    .i_clk     (I_CLOCK),
    .i_wr_en   (rx_push),
    .i_wr_addr (rx_wp_reg),
    .i_wr_data (rx_word),
    .i_rd_addr (rx_rp_reg),
    .o_rd_data (rx_q)
  );
endmodule : sfws_top
`default_nettype wire

/* sfws_top_tb.sv */
// Self-checking bench of the framing and status block
`default_nettype none
module sfws_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, cyc = 0, we = 0, go = 0;
  logic [7:0] adr = '0;
  logic [31:0] dat = '0, wd = '0, rdat, rx, t, p, r;
  logic ack, sdo, sck, sdi, done;
  logic [63:0] eq[$], sq[$];
  int err_count = 0, comparisons = 0;
  always #20 clk = !clk;
  sfws_top i_dut (.I_CLOCK(clk), .I_ARST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(cyc), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(dat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_SCK(sck),
    .I_SDI(sdi), .I_SEL(1'b0), .O_SDO(sdo), .O_SEL(), .O_SEL_OE());
  sfws_host_model i_host (.i_go(go), .i_len(6'd8), .i_word(wd), .i_sdo(sdo), .o_sck(sck),
    .o_sdi(sdi), .o_rx(rx), .o_done(done));
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [63:0] x);
    comparisons++;
    if ((got & x[63:32]) !== x[31:0])
    begin
      err_count++;
      $display("unexpected at %0t: %h not %h", $time, got & x[63:32], x[31:0]);
    end
  endtask : chk
  task automatic hang;
    err_count++;
    $display("unexpected at %0t: no answer", $time);
    give_verdict();
  endtask : hang
  always @(posedge clk)
    if (ack === 1'b1 && we === 1'b0 && eq.size() > 0)
      chk(rdat, eq.pop_front());
  always @(posedge done)
    chk(rx, sq.pop_front());
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1);
    int n;
    if (!w)
      eq.push_back({m, d & m});
    {cyc, we, adr, dat} <= {1'b1, w, a, w ? d : 32'h0};
    n = 0;
    do
      @(posedge clk);
    while (ack !== 1'b1 && ++n < 50);
    if (n == 50)
      hang();
    {cyc, we} <= 2'b00;
    @(posedge clk);
  endtask : bus
  task automatic xf(input logic [31:0] w, input logic [31:0] e, input logic [31:0] m);
    int n;
    sq.push_back({m, e & m});
    {wd, go} <= {w, 1'b1};
    n = 0;
    do
      @(posedge clk);
    while (done !== 1'b1 && ++n < 400);
    if (n == 400)
      hang();
    go <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : xf
  initial
  begin
    t = $urandom(18) & 32'hff;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, 8'h0c, 32'h28, 32'hff7f);
    bus(0, 8'h1c, 32'h0);
    bus(1, 8'h08, 32'h3f);
    bus(0, 8'h08, 32'h1f);
    bus(1, 8'h08, 32'h7);
    bus(1, 8'h00, 32'h8000);
    r = $urandom;
    bus(1, 8'h14, t);
    bus(0, 8'h0c, 32'h22);
    xf(r, t, 32'hff);
    bus(0, 8'h0c, 32'h89);
    bus(0, 8'h14, r, 32'hff);
    bus(0, 8'h0c, 32'ha8);
    p = $urandom;
    r = $urandom;
    bus(1, 8'h18, p);
    bus(1, 8'h04, 32'h1400);
    xf(r, p, 32'hff);
    xf($urandom, p, 32'hff);
    bus(0, 8'h0c, 32'h41, 32'h41);
    bus(0, 8'h14, r, 32'hff);
    bus(1, 8'h0c, 32'h40);
    bus(0, 8'h0c, 32'h0, 32'h40);
    bus(1, 8'h04, 32'h0);
    xf($urandom, 32'h0, 32'h0);
    bus(0, 8'h0c, 32'h120, 32'h121);
    bus(1, 8'h00, 32'h0);
    bus(0, 8'h0c, 32'h0, 32'h100);
    bus(1, 8'h00, 32'h8000);
    bus(1, 8'h04, 32'hffff);
    bus(0, 8'h04, 32'h74ff);
    bus(1, 8'h00, 32'h0);
    bus(1, 8'h04, 32'h8b00);
    bus(0, 8'h04, 32'h8b00);
    bus(1, 8'h04, 32'h0);
    bus(1, 8'h00, 32'h8001);
    bus(1, 8'h14, t);
    bus(1, 8'h14, r);
    bus(0, 8'h10, 32'h2, 32'h3f3f);
    bus(0, 8'h0c, 32'h20, 32'h2b);
    give_verdict();
  end
endmodule : sfws_top_tb
`default_nettype wire
